// *** src/ssc_pkg.sv ***
`default_nettype none
package ssc_pkg;
   // documented port widths and options
   localparam int SYMBOL_W_DEF    = 8;
   localparam int NUM_SYMBOLS_DEF = 4;
   localparam int CHANNEL_W_DEF   = 1;
   localparam int ERROR_W_DEF     = 1;
   localparam int EMPTY_W_DEF     = 1;
   localparam int READY_LAT_DEF   = 0;
   localparam int READY_LAT_MAX   = 8;
   localparam int MAX_CHANNEL_DEF = 1;
   localparam int API_CALL_W_DEF  = 64;
   localparam int API_RET_W_DEF   = 64;
   localparam int QUEUE_DEPTH_DEF = 16;
   localparam int IDLE_W          = 32;
   localparam int REG_W           = 32;
   localparam int ADR_W           = 8;
   localparam int WORD_SHIFT      = 2;

   // register byte addresses
   localparam logic [7:0] ADR_CTRL   = 8'h00;
   localparam logic [7:0] ADR_CMD    = 8'h04;
   localparam logic [7:0] ADR_STATUS = 8'h08;
   localparam logic [7:0] ADR_FLAGS  = 8'h0c;
   localparam logic [7:0] ADR_IDLES  = 8'h10;
   localparam logic [7:0] ADR_CHAN   = 8'h14;
   localparam logic [7:0] ADR_PKT    = 8'h18;
   localparam logic [7:0] ADR_EMPTY  = 8'h1c;
   localparam logic [7:0] ADR_ERROR  = 8'h20;
   localparam logic [7:0] ADR_DATA   = 8'h80;

   // field positions
   localparam int CTRL_READY   = 0;
   localparam int CMD_POP      = 0;
   localparam int CMD_FLUSH    = 1;
   localparam int ST_COUNT_W   = 16;
   localparam int ST_READY     = 16;
   localparam int ST_CUR_VALID = 17;
   localparam int FLG_OVERFLOW = 0;
   localparam int FLG_CHAN_RNG = 1;
   localparam int FLG_POP_EMPTY = 2;
   localparam int FLG_W        = 3;
   localparam int PKT_SOP      = 0;
   localparam int PKT_EOP      = 1;

   // command port word layout
   localparam int CMD_WE_BIT  = 63;
   localparam int CMD_ADR_LSB = 32;

   localparam logic RESET_READY = 1'b0;
endpackage : ssc_pkg
`default_nettype wire

// *** src/ssc_ready_delay.sv ***
`default_nettype none
module ssc_ready_delay #(
   parameter int DEPTH = 0
) (
   input  wire logic clk_i,
   input  wire logic rst_i,
   input  wire logic d_i,
   output logic      q_o
);
   generate
      if (DEPTH == 0) begin : g_direct
         assign q_o = d_i;
      end else begin : g_shift
         logic [DEPTH-1:0] hist;
         always_ff @(posedge clk_i) begin
            if (rst_i) begin
               hist <= '0;
            end else begin
               hist <= DEPTH'({hist, d_i});
            end
         end
         assign q_o = hist[DEPTH-1];
         a_ready_latency_tap: assert property (
            @(posedge clk_i) disable iff (rst_i)
            q_o == $past(d_i, DEPTH))
            else $error("ready tap does not match configured latency");
      end
   endgenerate
endmodule : ssc_ready_delay
`default_nettype wire

// *** src/ssc_desc_queue.sv ***
`default_nettype none
module ssc_desc_queue #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16,
   parameter int CNT_W = $clog2(DEPTH + 1)
) (
   input  wire logic             clk_i,
   input  wire logic             rst_i,
   input  wire logic             flush_i,
   input  wire logic             push_valid_i,
   input  wire logic [WIDTH-1:0] push_data_i,
   output logic                  push_ready_o,
   input  wire logic             pop_ready_i,
   output logic                  pop_valid_o,
   output logic [WIDTH-1:0]      pop_data_o,
   output logic [CNT_W-1:0]      count_o
);
   localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(DEPTH - 1);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [PTR_W-1:0] wr_ptr;
   logic [PTR_W-1:0] rd_ptr;
   logic             push;
   logic             pop;

   // a push into a full queue is refused even if a pop frees a slot
   assign push_ready_o = (count_o != CNT_W'(DEPTH));
   assign pop_valid_o  = (count_o != '0);
   assign push         = push_valid_i & push_ready_o;
   assign pop          = pop_ready_i & pop_valid_o;
   assign pop_data_o   = mem[rd_ptr];

   always_ff @(posedge clk_i) begin
      if (push) begin
         mem[wr_ptr] <= push_data_i;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i || flush_i) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end else begin
         if (push) begin
            wr_ptr <= (wr_ptr == PTR_LAST) ? '0 : PTR_W'(wr_ptr + 1'b1);
         end
         if (pop) begin
            rd_ptr <= (rd_ptr == PTR_LAST) ? '0 : PTR_W'(rd_ptr + 1'b1);
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i || flush_i) begin
         count_o <= '0;
      end else if (push && !pop) begin
         count_o <= CNT_W'(count_o + 1'b1);
      end else if (pop && !push) begin
         count_o <= CNT_W'(count_o - 1'b1);
      end
   end
endmodule : ssc_desc_queue
`default_nettype wire

// *** src/ssc_stream_sink.sv ***
// Decided for this implementation: the placing of the registers and register access over Wishbone.
`default_nettype none
module ssc_stream_sink #(
   parameter int   SYMBOL_W    = ssc_pkg::SYMBOL_W_DEF,
   parameter int   NUM_SYMBOLS = ssc_pkg::NUM_SYMBOLS_DEF,
   parameter int   CHANNEL_W   = ssc_pkg::CHANNEL_W_DEF,
   parameter int   ERROR_W     = ssc_pkg::ERROR_W_DEF,
   parameter int   EMPTY_W     = ssc_pkg::EMPTY_W_DEF,
   parameter int   READY_LAT   = ssc_pkg::READY_LAT_DEF,
   parameter int   MAX_CHANNEL = ssc_pkg::MAX_CHANNEL_DEF,
   parameter int   API_CALL_W  = ssc_pkg::API_CALL_W_DEF,
   parameter int   API_RET_W   = ssc_pkg::API_RET_W_DEF,
   parameter int   QUEUE_DEPTH = ssc_pkg::QUEUE_DEPTH_DEF,
   parameter bit   USE_PACKETS = 1'b0,
   parameter bit   USE_CHANNEL = 1'b0,
   parameter bit   USE_ERROR   = 1'b0,
   parameter bit   USE_READY   = 1'b1,
   parameter bit   USE_VALID   = 1'b1,
   parameter bit   USE_EMPTY   = 1'b0,
   parameter int   DATA_W      = SYMBOL_W * NUM_SYMBOLS
) (
   input  wire logic                    clk_i,
   input  wire logic                    rst_i,
   // register bus
   input  wire logic                    wb_cyc_i,
   input  wire logic                    wb_stb_i,
   input  wire logic                    wb_we_i,
   input  wire logic [ssc_pkg::ADR_W-1:0] wb_adr_i,
   input  wire logic [3:0]              wb_sel_i,
   input  wire logic [ssc_pkg::REG_W-1:0] wb_dat_i,
   output logic [ssc_pkg::REG_W-1:0]    wb_dat_o,
   output logic                         wb_ack_o,
   // command port
   input  wire logic                    cmd_valid_i,
   input  wire logic [API_CALL_W-1:0]   cmd_data_i,
   output logic                         ret_valid_o,
   output logic [API_RET_W-1:0]         ret_data_o,
   // stream from the source under test
   input  wire logic                    st_valid_i,
   input  wire logic [DATA_W-1:0]       st_data_i,
   input  wire logic [CHANNEL_W-1:0]    st_channel_i,
   input  wire logic [ERROR_W-1:0]      st_error_i,
   input  wire logic                    st_sop_i,
   input  wire logic                    st_eop_i,
   input  wire logic [EMPTY_W-1:0]      st_empty_i,
   output logic                         st_ready_o,
   // events
   output logic                         evt_ready_up_o,
   output logic                         evt_ready_down_o,
   output logic                         evt_received_o
);
   localparam int REG_W   = ssc_pkg::REG_W;
   localparam int ADR_W   = ssc_pkg::ADR_W;
   localparam int IDLE_W  = ssc_pkg::IDLE_W;
   // descriptor layout
   localparam int D_DATA  = 0;
   localparam int D_CHAN  = D_DATA + DATA_W;
   localparam int D_SOP   = D_CHAN + CHANNEL_W;
   localparam int D_EOP   = D_SOP + 1;
   localparam int D_EMPTY = D_EOP + 1;
   localparam int D_ERR   = D_EMPTY + EMPTY_W;
   localparam int D_IDLE  = D_ERR + ERROR_W;
   localparam int DESC_W  = D_IDLE + IDLE_W;
   localparam int CNT_W   = $clog2(QUEUE_DEPTH + 1);
   localparam int WORDS   = (DATA_W + REG_W - 1) / REG_W;
   localparam int PAD_W   = WORDS * REG_W;
   localparam int IDX_W   = ADR_W - ssc_pkg::WORD_SHIFT;
   localparam logic [IDLE_W-1:0] IDLE_SAT = '1;

   // access decode, shared by the bus and the command port
   logic                    wb_req;
   logic                    cmd_take;
   logic                    acc;
   logic                    acc_we;
   logic [ADR_W-1:0]        acc_adr;
   logic [REG_W-1:0]        acc_wdat;
   logic                    acc_b0;
   logic                    wr;
   logic [REG_W-1:0]        rdat;
   logic [IDX_W-1:0]        data_idx;
   logic [PAD_W-1:0]        data_pad;

   // stream side
   logic                    ready_seen;
   logic                    eff_valid;
   logic                    eff_ready;
   logic                    beat;
   logic [DESC_W-1:0]       desc_in;
   logic [IDLE_W-1:0]       idle_cnt;

   // queue and current descriptor
   logic                    q_ready;
   logic                    q_valid;
   logic [DESC_W-1:0]       q_head;
   logic [CNT_W-1:0]        q_count;
   logic                    pop_req;
   logic                    flush_req;
   logic                    do_pop;
   logic [DESC_W-1:0]       cur;
   logic                    cur_valid;
   logic [ssc_pkg::FLG_W-1:0] flags;
   logic [ssc_pkg::FLG_W-1:0] flag_set;
   logic [ssc_pkg::FLG_W-1:0] flag_clr;
   logic                    chan_over;

   // the bus wins a tie; the command port simply waits a cycle
   assign wb_req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign cmd_take = cmd_valid_i & ~wb_req & ~ret_valid_o;
   assign acc      = wb_req | cmd_take;
   assign acc_we   = wb_req ? wb_we_i
                            : cmd_data_i[ssc_pkg::CMD_WE_BIT];
   assign acc_adr  = wb_req ? wb_adr_i
                            : cmd_data_i[ssc_pkg::CMD_ADR_LSB +: ADR_W];
   assign acc_wdat = wb_req ? wb_dat_i : cmd_data_i[REG_W-1:0];
   assign acc_b0   = wb_req ? wb_sel_i[0] : 1'b1;
   assign wr       = acc & acc_we & acc_b0;

   assign pop_req   = wr && (acc_adr == ssc_pkg::ADR_CMD)
                      && acc_wdat[ssc_pkg::CMD_POP];
   assign flush_req = wr && (acc_adr == ssc_pkg::ADR_CMD)
                      && acc_wdat[ssc_pkg::CMD_FLUSH];
   assign do_pop    = pop_req & q_valid;

   // missing valid or ready ports degrade to constant high
   assign eff_valid = USE_VALID ? st_valid_i : 1'b1;
   assign eff_ready = USE_READY ? ready_seen : 1'b1;
   assign beat      = eff_valid & eff_ready;

   ssc_ready_delay #(
      .DEPTH (READY_LAT)
   ) u_ready_delay (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .d_i   (st_ready_o),
      .q_o   (ready_seen)
   );

   // disabled options capture as zero so descriptors stay comparable
   always_comb begin
      desc_in = '0;
      desc_in[D_DATA +: DATA_W] = st_data_i;
      if (USE_CHANNEL) begin
         desc_in[D_CHAN +: CHANNEL_W] = st_channel_i;
      end
      if (USE_PACKETS) begin
         desc_in[D_SOP] = st_sop_i;
         desc_in[D_EOP] = st_eop_i;
      end
      if (USE_PACKETS && USE_EMPTY) begin
         desc_in[D_EMPTY +: EMPTY_W] = st_empty_i;
      end
      if (USE_ERROR) begin
         desc_in[D_ERR +: ERROR_W] = st_error_i;
      end
      desc_in[D_IDLE +: IDLE_W] = idle_cnt;
   end

   ssc_desc_queue #(
      .WIDTH (DESC_W),
      .DEPTH (QUEUE_DEPTH),
      .CNT_W (CNT_W)
   ) u_queue (
      .clk_i        (clk_i),
      .rst_i        (rst_i),
      .flush_i      (flush_req),
      .push_valid_i (beat),
      .push_data_i  (desc_in),
      .push_ready_o (q_ready),
      .pop_ready_i  (pop_req),
      .pop_valid_o  (q_valid),
      .pop_data_o   (q_head),
      .count_o      (q_count)
   );

   // idle count saturates instead of wrapping on long gaps
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         idle_cnt <= '0;
      end else if (beat) begin
         idle_cnt <= '0;
      end else if (idle_cnt != IDLE_SAT) begin
         idle_cnt <= IDLE_W'(idle_cnt + 1'b1);
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_ready_o       <= ssc_pkg::RESET_READY;
         evt_ready_up_o   <= 1'b0;
         evt_ready_down_o <= 1'b0;
      end else begin
         evt_ready_up_o   <= 1'b0;
         evt_ready_down_o <= 1'b0;
         if (USE_READY && wr && acc_adr == ssc_pkg::ADR_CTRL) begin
            st_ready_o <= acc_wdat[ssc_pkg::CTRL_READY];
            evt_ready_up_o <= acc_wdat[ssc_pkg::CTRL_READY]
                              & ~st_ready_o;
            evt_ready_down_o <= ~acc_wdat[ssc_pkg::CTRL_READY]
                                & st_ready_o;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         evt_received_o <= 1'b0;
      end else begin
         evt_received_o <= beat & q_ready;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cur       <= '0;
         cur_valid <= 1'b0;
      end else if (do_pop) begin
         cur       <= q_head;
         cur_valid <= 1'b1;
      end
   end

   // out-of-range channels are still queued, only flagged
   assign chan_over = USE_CHANNEL
                      && (32'(st_channel_i) > 32'(MAX_CHANNEL));

   always_comb begin
      flag_set = '0;
      flag_set[ssc_pkg::FLG_OVERFLOW]  = beat & ~q_ready;
      flag_set[ssc_pkg::FLG_CHAN_RNG]  = beat & chan_over;
      flag_set[ssc_pkg::FLG_POP_EMPTY] = pop_req & ~q_valid;
      flag_clr = '0;
      if (wr && acc_adr == ssc_pkg::ADR_FLAGS) begin
         flag_clr = acc_wdat[ssc_pkg::FLG_W-1:0];
      end
   end

   // a new event in the clearing cycle survives the clear
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         flags <= '0;
      end else begin
         flags <= (flags & ~flag_clr) | flag_set;
      end
   end

   assign data_pad = PAD_W'(cur[D_DATA +: DATA_W]);
   assign data_idx = IDX_W'((acc_adr - ssc_pkg::ADR_DATA)
                            >> ssc_pkg::WORD_SHIFT);

   always_comb begin
      rdat = '0;
      if (acc_adr >= ssc_pkg::ADR_DATA) begin
         if (32'(data_idx) < 32'(WORDS)) begin
            rdat = data_pad[data_idx*REG_W +: REG_W];
         end
      end else begin
         unique case (acc_adr)
            ssc_pkg::ADR_CTRL: begin
               rdat[ssc_pkg::CTRL_READY] = st_ready_o;
            end
            ssc_pkg::ADR_STATUS: begin
               rdat[ssc_pkg::ST_COUNT_W-1:0] =
                  ssc_pkg::ST_COUNT_W'(q_count);
               rdat[ssc_pkg::ST_READY]     = st_ready_o;
               rdat[ssc_pkg::ST_CUR_VALID] = cur_valid;
            end
            ssc_pkg::ADR_FLAGS: begin
               rdat[ssc_pkg::FLG_W-1:0] = flags;
            end
            ssc_pkg::ADR_IDLES: begin
               rdat = cur[D_IDLE +: IDLE_W];
            end
            ssc_pkg::ADR_CHAN: begin
               rdat = 32'(cur[D_CHAN +: CHANNEL_W]);
            end
            ssc_pkg::ADR_PKT: begin
               rdat[ssc_pkg::PKT_SOP] = cur[D_SOP];
               rdat[ssc_pkg::PKT_EOP] = cur[D_EOP];
            end
            ssc_pkg::ADR_EMPTY: begin
               rdat = 32'(cur[D_EMPTY +: EMPTY_W]);
            end
            ssc_pkg::ADR_ERROR: begin
               rdat = 32'(cur[D_ERR +: ERROR_W]);
            end
            default: begin
               rdat = '0;
            end
         endcase
      end
   end

   // every bus access, mapped or not, is acked one cycle after the request
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= '0;
      end else begin
         wb_ack_o <= wb_req;
         wb_dat_o <= (wb_req && !wb_we_i) ? rdat : '0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ret_valid_o <= 1'b0;
         ret_data_o  <= '0;
      end else begin
         ret_valid_o <= cmd_take;
         ret_data_o  <= cmd_take ? API_RET_W'(rdat) : '0;
      end
   end

   a_ready_after_reset: assert property (
      @(posedge clk_i) disable iff (rst_i)
      $fell(rst_i) |-> !st_ready_o && q_count == '0 && idle_cnt == '0)
      else $error("sink not idle after reset");

   a_ready_up_event: assert property (
      @(posedge clk_i) disable iff (rst_i)
      $rose(st_ready_o) |-> evt_ready_up_o && !evt_ready_down_o)
      else $error("ready rose without its event");

   a_ready_down_event: assert property (
      @(posedge clk_i) disable iff (rst_i)
      evt_ready_down_o |-> $fell(st_ready_o))
      else $error("ready-low event without ready falling");

   a_ready_port_off: assert property (
      @(posedge clk_i) disable iff (rst_i)
      !USE_READY |-> !st_ready_o)
      else $error("ready moved although the ready port is off");

   a_received_pulse: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (beat && q_ready && !flush_req) |=>
         evt_received_o && q_count != '0)
      else $error("queued beat without received event");

   a_idle_restart: assert property (
      @(posedge clk_i) disable iff (rst_i)
      beat ##1 !beat |=> idle_cnt == IDLE_W'(1))
      else $error("idle count did not restart after a beat");

   a_pop_count: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (do_pop && !beat && !flush_req) |=>
         q_count == CNT_W'($past(q_count) - 1'b1) && cur_valid)
      else $error("pop did not remove exactly one descriptor");

   a_no_beat_blocked: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (USE_READY && !ready_seen) |=> !evt_received_o)
      else $error("beat accepted while ready was low");

   a_chan_flagged: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (beat && chan_over) |=> flags[ssc_pkg::FLG_CHAN_RNG])
      else $error("out-of-range channel not recorded");
endmodule : ssc_stream_sink
`default_nettype wire

// *** bench/ssc_src_model.sv ***
`default_nettype none
// stands in for the source under test; assumes a ready latency of zero
module ssc_src_model (
   input  wire logic   clk_i,
   input  wire logic   st_ready_i,
   output logic        st_valid_o,
   output logic [31:0] st_data_o,
   output logic [1:0]  st_channel_o,
   output logic [3:0]  st_flags_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // edges since the last accepted beat, kept across calls
   int since = 0;
   always @(posedge clk_i) begin
      if (st_valid_o === 1'b1 && st_ready_i === 1'b1) since <= 0;
      else since <= since + 1;
   end
   initial begin
      st_valid_o   = 1'b0;
      st_data_o    = 32'h0;
      st_channel_o = 2'h0;
      st_flags_o   = 4'h0;
   end
   // valid drops and the other released lines are inverted so a stale beat never looks current
   task automatic release_lines();
      st_valid_o   <= 1'b0;
      st_data_o    <= ~st_data_o;
      st_channel_o <= ~st_channel_o;
      st_flags_o   <= ~st_flags_o;
   endtask : release_lines
   // idl returns the cycles without a beat before this one
   task automatic send(input logic [31:0] d, input logic [1:0] ch,
                       input logic [3:0] f, input int gap, output int idl);
      int waited;
      waited = 0;
      forever begin
         @(posedge clk_i);
         if (waited >= gap && st_ready_i === 1'b1) break;
         release_lines();
         waited++;
      end
      // the beat lands at the next edge; count idles up to it
      if (st_valid_o === 1'b1 && st_ready_i === 1'b1) idl = 0;
      else idl = since + 1;
      st_valid_o   <= 1'b1;
      st_data_o    <= d;
      st_channel_o <= ch;
      st_flags_o   <= f;
   endtask : send
   task automatic idle();
      @(posedge clk_i);
      release_lines();
   endtask : idle
endmodule : ssc_src_model
`default_nettype wire

// *** bench/tb.sv ***
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int DEPTH = ssc_pkg::QUEUE_DEPTH_DEF;
   logic        clk_i, rst_i = 1'b1, cyc = 1'b0, we = 1'b0;
   logic [7:0]  adr = 8'h0;
   logic [31:0] wdat = 32'h0, wb_dat_o, sdata;
   logic        wb_ack_o, cmd_valid = 1'b0, ret_valid_o, svalid, st_ready_o;
   logic [63:0] cmd_data = 64'h0, ret_data_o;
   logic [1:0]  schan;
   logic [3:0]  sflags, sel = 4'hf;
   logic        evt_ready_up_o, evt_ready_down_o, evt_received_o;
   int          error_cnt = 0, comparisons = 0, cycles = 0;
   int          up_n = 0, dn_n = 0, rx_n = 0;
   initial begin
      clk_i = 1'b0;
      forever #12.5 clk_i = ~clk_i;
   end
   ssc_stream_sink #(.CHANNEL_W(2),
      .USE_PACKETS(1'b1), .USE_CHANNEL(1'b1), .USE_ERROR(1'b1),
      .USE_EMPTY(1'b1)) i_dut (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .cmd_valid_i(cmd_valid),
      .cmd_data_i(cmd_data), .ret_valid_o(ret_valid_o),
      .ret_data_o(ret_data_o), .st_valid_i(svalid), .st_data_i(sdata),
      .st_channel_i(schan), .st_error_i(sflags[3]), .st_sop_i(sflags[0]),
      .st_eop_i(sflags[1]), .st_empty_i(sflags[2]), .st_ready_o(st_ready_o),
      .evt_ready_up_o(evt_ready_up_o), .evt_ready_down_o(evt_ready_down_o),
      .evt_received_o(evt_received_o));
   ssc_src_model i_src (.clk_i(clk_i), .st_ready_i(st_ready_o),
      .st_valid_o(svalid), .st_data_o(sdata), .st_channel_o(schan),
      .st_flags_o(sflags));
   task automatic report_and_stop();
      $display("errors %0d comparisons %0d", error_cnt, comparisons);
      if (error_cnt == 0 && comparisons > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : report_and_stop
   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      if (evt_ready_up_o === 1'b1) up_n <= up_n + 1;
      if (evt_ready_down_o === 1'b1) dn_n <= dn_n + 1;
      if (evt_received_o === 1'b1) rx_n <= rx_n + 1;
      // the whole sequence needs well under a thousand cycles
      if (cycles == 20000) begin
         error_cnt++;
         $display("BAD %0t timeout", $time);
         report_and_stop();
      end
   end
   task automatic check(input logic [63:0] got, exp, input string what);
      comparisons++;
      if (got !== exp) begin
         error_cnt++;
         $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : check
   task automatic wb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r);
      @(posedge clk_i);
      cyc  <= 1'b1;
      we   <= w;
      adr  <= a;
      wdat <= d;
      do @(posedge clk_i); while (wb_ack_o !== 1'b1);
      r = wb_dat_o;
      cyc <= 1'b0;
   endtask : wb
   task automatic cmd(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [63:0] r);
      @(posedge clk_i);
      cmd_valid <= 1'b1;
      cmd_data  <= {w, 23'h0, a, d};
      do @(posedge clk_i); while (ret_valid_o !== 1'b1);
      r = ret_data_o;
      cmd_valid <= 1'b0;
   endtask : cmd
   task automatic rd_check(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] r;
      wb(1'b0, a, 32'h0, r);
      check({32'h0, r}, {32'h0, e}, "register read");
   endtask : rd_check
   task automatic pop_check(input logic [31:0] d, input logic [1:0] ch,
                            input logic [3:0] f, input int idl);
      logic [31:0] r;
      wb(1'b1, ssc_pkg::ADR_CMD, 32'h1 << ssc_pkg::CMD_POP, r);
      rd_check(ssc_pkg::ADR_DATA, d);
      rd_check(ssc_pkg::ADR_CHAN, {30'h0, ch});
      rd_check(ssc_pkg::ADR_PKT, {30'h0, f[1:0]});
      rd_check(ssc_pkg::ADR_EMPTY, {31'h0, f[2]});
      rd_check(ssc_pkg::ADR_ERROR, {31'h0, f[3]});
      if (idl >= 0) rd_check(ssc_pkg::ADR_IDLES, 32'(idl));
   endtask : pop_check
   initial begin
      int          n0, n1, n2, n;
      logic [31:0] r;
      logic [63:0] q;
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      rd_check(ssc_pkg::ADR_STATUS, 32'h0);
      check({63'h0, st_ready_o}, 64'h0, "ready after reset");
      rd_check(8'h40, 32'h0);
      wb(1'b1, ssc_pkg::ADR_CTRL, 32'h1, r);
      @(posedge clk_i);
      check(64'(up_n), 64'h1, "ready up event");
      rd_check(ssc_pkg::ADR_STATUS, 32'h1 << ssc_pkg::ST_READY);
      i_src.send(32'h11223344, 2'h0, 4'h1, 0, n0);
      i_src.send(32'ha5a50f0f, 2'h1, 4'he, 0, n1);
      i_src.send(32'h000000ff, 2'h1, 4'h2, 3, n2);
      i_src.idle();
      repeat (2) @(posedge clk_i);
      check(64'(rx_n), 64'h3, "received events");
      rd_check(ssc_pkg::ADR_STATUS, 32'h10003);
      pop_check(32'h11223344, 2'h0, 4'h1, -1);
      pop_check(32'ha5a50f0f, 2'h1, 4'he, n1);
      pop_check(32'h000000ff, 2'h1, 4'h2, n2);
      rd_check(ssc_pkg::ADR_FLAGS, 32'h0);
      // one beat more than the queue holds, the first on an extra channel
      for (int i = 0; i <= DEPTH; i++) begin
         i_src.send(32'h100 + i, (i == 0) ? 2'h2 : 2'h0, 4'h0, 0, n);
         if (i == 0) n0 = n;
      end
      i_src.idle();
      repeat (2) @(posedge clk_i);
      check(64'(rx_n), 64'(3 + DEPTH), "events when full");
      rd_check(ssc_pkg::ADR_FLAGS, 32'h3);
      pop_check(32'h100, 2'h2, 4'h0, n0);
      wb(1'b1, ssc_pkg::ADR_CMD, 32'h1 << ssc_pkg::CMD_FLUSH, r);
      rd_check(ssc_pkg::ADR_STATUS, 32'h30000);
      wb(1'b1, ssc_pkg::ADR_CMD, 32'h1 << ssc_pkg::CMD_POP, r);
      rd_check(ssc_pkg::ADR_FLAGS, 32'h7);
      // a write without byte lane 0 must leave the flags alone
      sel <= 4'he;
      wb(1'b1, ssc_pkg::ADR_FLAGS, 32'h7, r);
      rd_check(ssc_pkg::ADR_FLAGS, 32'h7);
      sel <= 4'hf;
      wb(1'b1, ssc_pkg::ADR_FLAGS, 32'h7, r);
      rd_check(ssc_pkg::ADR_FLAGS, 32'h0);
      cmd(1'b1, ssc_pkg::ADR_CTRL, 32'h0, q);
      @(posedge clk_i);
      check(64'(dn_n), 64'h1, "ready down event");
      check({63'h0, st_ready_o}, 64'h0, "ready after command");
      cmd(1'b0, ssc_pkg::ADR_CHAN, 32'h0, q);
      check(q, 64'h2, "command read");
      report_and_stop();
   end
endmodule : tb
`default_nettype wire
